// File: hdl/eof_event_flags.sv
// overhead event detection, sticky flags and interrupt for one E1 channel
//
// Register access over AHB-Lite is this design's own decision.
`default_nettype none

module eof_event_flags #(
  parameter int RAI_HOLD_CYCLES = int'(eof_pkg::RAI_CYCLES),
  parameter int SECOND_LEN_CYCLES = int'(eof_pkg::SECOND_CYCLES)
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic crc_mf_sync,
  input wire logic basic_frame_sync,
  input wire logic smf_valid,
  input wire logic [3:0] nat4_code,
  input wire logic [3:0] nat5_code,
  input wire logic [3:0] nat6_code,
  input wire logic [3:0] nat7_code,
  input wire logic [3:0] nat8_code,
  input wire logic sa6_bit_valid,
  input wire logic sa6_bit,
  input wire logic sa7_bit_valid,
  input wire logic sa7_bit,
  input wire logic e_bit_valid,
  input wire logic e_bit,
  input wire logic a_bit,
  output logic irq_n
);

  eof_pkg::eof_state_type s_r;
  eof_pkg::eof_state_type s_nxt;
  logic [4:0][3:0] codes;
  logic [7:0] sa_pending;
  logic [7:0] ovh_pending;

  // ==========================================================
  // helpers
  function automatic logic is_special(input logic [11:0] w);
    is_special = (w == eof_pkg::SPECIAL_888) || (w == eof_pkg::SPECIAL_AAA)
      || (w == eof_pkg::SPECIAL_CCC) || (w == eof_pkg::SPECIAL_EEE)
      || (w == eof_pkg::SPECIAL_FFF);
  endfunction : is_special

  // unmapped indices read as zero
  function automatic logic [31:0] read_reg(input logic [7:0] idx,
      input eof_pkg::eof_state_type st);
    logic [7:0] b;
    b = eof_pkg::RESET_BYTE;
    if (idx == eof_pkg::IDX_SA_CTRL) begin
      b = st.sa_ctrl;
    end else if (idx == eof_pkg::IDX_SA_FLAGS) begin
      b = st.sa_flags & eof_pkg::SA_FLAGS_MASK;
    end else if (idx == eof_pkg::IDX_OVH_STATUS) begin
      b = {5'h00, st.rai_stat, st.cf_stat, st.link_stat};
    end else if (idx == eof_pkg::IDX_OVH_ENABLES) begin
      b = st.ovh_en & eof_pkg::OVH_MASK;
    end else if (idx == eof_pkg::IDX_OVH_FLAGS) begin
      b = st.ovh_flags & eof_pkg::OVH_MASK;
    end else if (idx >= eof_pkg::IDX_CODE_FIRST
        && idx <= eof_pkg::IDX_CODE_LAST) begin
      b = {4'h0, st.code_cur[3'(eof_pkg::IDX_CODE_LAST - idx)]};
    end
    read_reg = {24'h000000, b};
  endfunction : read_reg

  // index 4 is the Sa4 channel down to index 0 for Sa8, as in the flags
  assign codes = {nat4_code, nat5_code, nat6_code, nat7_code, nat8_code};

  // ==========================================================
  // next state
  always_comb begin
    logic wr;
    logic [7:0] w1c;
    logic [7:0] sa_set;
    logic [7:0] ovh_set;
    logic [11:0] sh;
    logic [2:0] h7;
    logic rai_cond;
    logic [15:0] zc;
    wr = 1'b0;
    w1c = 8'h00;
    sa_set = 8'h00;
    ovh_set = 8'h00;
    sh = 12'h000;
    h7 = 3'h0;
    rai_cond = 1'b0;
    zc = 16'h0000;
    s_nxt = s_r;

    // stored codewords follow the sub-multiframe, held out of sync
    if (smf_valid && crc_mf_sync) begin
      for (int k = 0; k < 5; k++) begin
        if (!s_r.sa_ctrl[eof_pkg::CTRL_DEBOUNCE]
            || codes[k] == s_r.code_prev[k]) begin
          s_nxt.code_cur[k] = codes[k];
        end
        if (s_nxt.code_cur[k] != s_r.code_cur[k]) begin
          sa_set[k] = 1'b1;
        end
        s_nxt.code_prev[k] = codes[k];
      end
      if (codes[2] == eof_pkg::NT_CRC_CODE_A
          || codes[2] == eof_pkg::NT_CRC_CODE_B) begin
        ovh_set[eof_pkg::OVH_NT_CRC] = 1'b1;
      end
      if (codes[2] == eof_pkg::NT_FAR_CODE_A
          || codes[2] == eof_pkg::NT_FAR_CODE_B) begin
        ovh_set[eof_pkg::OVH_NT_FAR] = 1'b1;
      end
    end

    // special Sa6 patterns: serial window or three aligned words
    if (!crc_mf_sync) begin
      s_nxt.sa6_bcnt = 4'h0;
      s_nxt.sa6_wcnt = 2'h0;
    end else if (s_r.sa_ctrl[eof_pkg::CTRL_COMPARE_MODE]) begin
      if (smf_valid) begin
        sh = {s_r.sa6_words[7:0], codes[2]};
        s_nxt.sa6_words = sh;
        if (s_r.sa6_wcnt != eof_pkg::SA6_WORDS_NEEDED) begin
          s_nxt.sa6_wcnt = s_r.sa6_wcnt + 2'h1;
        end
        if (s_nxt.sa6_wcnt == eof_pkg::SA6_WORDS_NEEDED
            && is_special(sh)) begin
          sa_set[eof_pkg::SA_SPECIAL] = 1'b1;
        end
      end
    end else if (sa6_bit_valid) begin
      sh = {s_r.sa6_bits[10:0], sa6_bit};
      s_nxt.sa6_bits = sh;
      if (s_r.sa6_bcnt != eof_pkg::SA6_BITS_NEEDED) begin
        s_nxt.sa6_bcnt = s_r.sa6_bcnt + 4'h1;
      end
      if (s_nxt.sa6_bcnt == eof_pkg::SA6_BITS_NEEDED
          && is_special(sh)) begin
        sa_set[eof_pkg::SA_SPECIAL] = 1'b1;
      end
    end

    // far end block errors, suspended out of multiframe sync
    if (e_bit_valid && crc_mf_sync) begin
      s_nxt.e_zero_last = !e_bit;
      if (!e_bit) begin
        ovh_set[eof_pkg::OVH_FAR_BLOCK] = 1'b1;
      end
    end

    // continuous RAI and FEBE: condition unbroken for the hold time
    rai_cond = a_bit && s_nxt.e_zero_last && crc_mf_sync;
    if (!rai_cond) begin
      s_nxt.rai_cnt = 32'h0;
      s_nxt.rai_stat = 1'b0;
    end else if (s_r.rai_cnt < 32'(RAI_HOLD_CYCLES)) begin
      s_nxt.rai_cnt = s_r.rai_cnt + 32'h1;
    end else begin
      s_nxt.rai_stat = 1'b1;
    end

    // continuous FEBE: one history bit per second of zeros counted
    if (!crc_mf_sync) begin
      s_nxt.sec_cnt = 32'h0;
      s_nxt.zero_cnt = 16'h0;
      s_nxt.cf_hist = '0;
      s_nxt.cf_stat = 1'b0;
      s_nxt.e_zero_last = 1'b0;
    end else begin
      zc = s_r.zero_cnt;
      if (e_bit_valid && !e_bit && zc != 16'hFFFF) begin
        zc = zc + 16'h1;
      end
      if (s_r.sec_cnt == 32'(SECOND_LEN_CYCLES - 1)) begin
        s_nxt.sec_cnt = 32'h0;
        s_nxt.zero_cnt = 16'h0;
        s_nxt.cf_hist = {s_r.cf_hist[eof_pkg::FEBE_SECONDS-2:0],
          zc >= eof_pkg::FEBE_MIN_PER_SEC};
        s_nxt.cf_stat = &s_nxt.cf_hist;
      end else begin
        s_nxt.sec_cnt = s_r.sec_cnt + 32'h1;
        s_nxt.zero_cnt = zc;
      end
    end

    // V5.2 link ID: sliding window of three Sa7 bits
    if (!basic_frame_sync) begin
      s_nxt.sa7_cnt = 2'h0;
      s_nxt.link_stat = 1'b0;
    end else if (sa7_bit_valid) begin
      h7 = {s_r.sa7_hist[1:0], sa7_bit};
      s_nxt.sa7_hist = h7;
      if (s_r.sa7_cnt != eof_pkg::SA7_WINDOW) begin
        s_nxt.sa7_cnt = s_r.sa7_cnt + 2'h1;
      end
      if (s_nxt.sa7_cnt == eof_pkg::SA7_WINDOW) begin
        s_nxt.link_stat = ({1'b0, !h7[0]} + {1'b0, !h7[1]}
          + {1'b0, !h7[2]}) >= eof_pkg::SA7_ZEROS_NEEDED;
      end
    end

    // status transitions in either direction
    ovh_set[eof_pkg::OVH_RAI_FAR] = s_nxt.rai_stat != s_r.rai_stat;
    ovh_set[eof_pkg::OVH_CONT_FAR] = s_nxt.cf_stat != s_r.cf_stat;
    ovh_set[eof_pkg::OVH_LINK_ID] = s_nxt.link_stat != s_r.link_stat;

    // bus data phase: writes land now, reserved bits never stored
    wr = s_r.ap_valid && s_r.ap_write;
    if (wr && s_r.ap_idx == eof_pkg::IDX_SA_CTRL) begin
      s_nxt.sa_ctrl = hwdata[7:0];
    end else if (wr && s_r.ap_idx == eof_pkg::IDX_OVH_ENABLES) begin
      s_nxt.ovh_en = hwdata[7:0] & eof_pkg::OVH_MASK;
    end
    if (wr && (s_r.ap_idx == eof_pkg::IDX_SA_FLAGS
        || s_r.ap_idx == eof_pkg::IDX_OVH_FLAGS)) begin
      w1c = hwdata[7:0];
    end

    // a new event wins over a clear in the same cycle
    if (s_r.ap_idx == eof_pkg::IDX_SA_FLAGS) begin
      s_nxt.sa_flags = ((s_r.sa_flags & ~w1c) | sa_set)
        & eof_pkg::SA_FLAGS_MASK;
      s_nxt.ovh_flags = (s_r.ovh_flags | ovh_set) & eof_pkg::OVH_MASK;
    end else begin
      s_nxt.sa_flags = (s_r.sa_flags | sa_set) & eof_pkg::SA_FLAGS_MASK;
      s_nxt.ovh_flags = ((s_r.ovh_flags & ~w1c) | ovh_set)
        & eof_pkg::OVH_MASK;
    end

    // bus address phase: read data prepared from the updated state
    s_nxt.ap_valid = hsel && htrans[1] && hready;
    s_nxt.ap_write = hwrite;
    s_nxt.ap_idx = (haddr[31:10] == 22'h0) ? haddr[9:2] : 8'hFF;
    if (s_nxt.ap_valid && !hwrite) begin
      s_nxt.hrdata = read_reg(s_nxt.ap_idx, s_nxt);
    end
    if (!s_nxt.ap_valid) begin
      s_nxt.ap_write = 1'b0;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_r.hrdata;
  assign sa_pending = s_r.sa_flags & s_r.sa_ctrl & eof_pkg::SA_FLAGS_MASK;
  assign ovh_pending = s_r.ovh_flags & s_r.ovh_en;
  // pin low while any enabled flag pends
  assign irq_n = !(|sa_pending || |ovh_pending);

  // ==========================================================
  // checks
  chk_irq_nat_gate: assert property (@(posedge clk)
    disable iff (!resetn)
    (s_r.sa_flags[4] && s_r.sa_ctrl[4]) |-> !irq_n)
    else $error("national change flag enabled but pin idle");

  chk_irq_link_gate: assert property (@(posedge clk)
    disable iff (!resetn)
    (s_r.sa_flags == 8'h00 && s_r.ovh_flags == 8'h01 && !s_r.ovh_en[0])
    |-> irq_n)
    else $error("link change flag drove pin while disabled");

  chk_nat_change: assert property (@(posedge clk)
    disable iff (!resetn)
    (smf_valid && crc_mf_sync && !s_r.sa_ctrl[6]
     && nat4_code != s_r.code_cur[4])
    |=> (s_r.sa_flags[4] && s_r.code_cur[4] == $past(nat4_code)))
    else $error("codeword change not flagged");

  chk_debounce_hold: assert property (@(posedge clk)
    disable iff (!resetn)
    (smf_valid && s_r.sa_ctrl[6] && nat5_code != s_r.code_prev[3])
    |=> $stable(s_r.code_cur[3]))
    else $error("debounced codeword updated on first sight");

  chk_nt_crc_event: assert property (@(posedge clk)
    disable iff (!resetn)
    (smf_valid && crc_mf_sync && nat6_code == 4'h3)
    |=> (s_r.ovh_flags[5] && s_r.ovh_flags[4]))
    else $error("NT codeword 0011 missed");

  chk_febe_event: assert property (@(posedge clk)
    disable iff (!resetn)
    (e_bit_valid && !e_bit && crc_mf_sync) |=> s_r.ovh_flags[3])
    else $error("far end block error not flagged");

  chk_febe_suspend: assert property (@(posedge clk)
    disable iff (!resetn)
    (!crc_mf_sync && !s_r.ovh_flags[3] && !s_r.ap_valid)
    |=> !s_r.ovh_flags[3])
    else $error("block error flagged out of sync");

  chk_rai_change: assert property (@(posedge clk)
    disable iff (!resetn)
    $changed(s_r.rai_stat) |-> s_r.ovh_flags[2])
    else $error("RAI status transition not flagged");

  chk_cfebe_change: assert property (@(posedge clk)
    disable iff (!resetn)
    $changed(s_r.cf_stat) |-> s_r.ovh_flags[1])
    else $error("continuous FEBE transition not flagged");

  chk_rai_drop: assert property (@(posedge clk)
    disable iff (!resetn)
    (!crc_mf_sync || !a_bit) |=> !s_r.rai_stat)
    else $error("RAI status held without its condition");

  chk_link_two_zero: assert property (@(posedge clk)
    disable iff (!resetn)
    (basic_frame_sync && sa7_bit_valid && s_r.sa7_cnt == 2'h3
     && !sa7_bit && !s_r.sa7_hist[0]) |=> s_r.link_stat)
    else $error("link ID not seen after two zeros");

  chk_w1c_clear: assert property (@(posedge clk)
    disable iff (!resetn)
    (s_r.ap_valid && s_r.ap_write && s_r.ap_idx == 8'h61 && hwdata[3]
     && !(e_bit_valid && !e_bit && crc_mf_sync)) |=> !s_r.ovh_flags[3])
    else $error("write one did not clear flag");

  chk_w0_keep: assert property (@(posedge clk)
    disable iff (!resetn)
    (s_r.ap_valid && s_r.ap_write && s_r.ap_idx == 8'h61
     && !hwdata[3] && s_r.ovh_flags[3]) |=> s_r.ovh_flags[3])
    else $error("write zero cleared flag");

  chk_special_words: assert property (@(posedge clk)
    disable iff (!resetn)
    (smf_valid && crc_mf_sync && s_r.sa_ctrl[7] && s_r.sa6_wcnt >= 2'h2
     && nat6_code == 4'h8 && s_r.sa6_words[7:0] == 8'h88)
    |=> s_r.sa_flags[5])
    else $error("special codeword triple missed");

  chk_cfebe_sync: assert property (@(posedge clk)
    disable iff (!resetn)
    !crc_mf_sync |=> !s_r.cf_stat)
    else $error("continuous FEBE status held out of sync");

  chk_link_change: assert property (@(posedge clk)
    disable iff (!resetn)
    $changed(s_r.link_stat) |-> s_r.ovh_flags[0])
    else $error("link ID status transition not flagged");

  chk_irq_ovh_gate: assert property (@(posedge clk)
    disable iff (!resetn)
    (s_r.ovh_flags[3] && s_r.ovh_en[3]) |-> !irq_n)
    else $error("overhead flag enabled but pin idle");

endmodule : eof_event_flags
`default_nettype wire

// File: hdl/eof_pkg.sv
// constants, register map and state layout for the overhead event flag block
`default_nettype none
package eof_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_SA_CTRL = 8'h5C;
  localparam logic [7:0] IDX_SA_FLAGS = 8'h5D;
  localparam logic [7:0] IDX_OVH_STATUS = 8'h5F;
  localparam logic [7:0] IDX_OVH_ENABLES = 8'h60;
  localparam logic [7:0] IDX_OVH_FLAGS = 8'h61;
  localparam logic [7:0] IDX_CODE_FIRST = 8'h56;
  localparam logic [7:0] IDX_CODE_LAST = 8'h5A;

  // ==========================================================
  // field positions
  localparam int CTRL_COMPARE_MODE = 7;
  localparam int CTRL_DEBOUNCE = 6;
  localparam int SA_SPECIAL = 5;
  localparam int OVH_NT_CRC = 5;
  localparam int OVH_NT_FAR = 4;
  localparam int OVH_FAR_BLOCK = 3;
  localparam int OVH_RAI_FAR = 2;
  localparam int OVH_CONT_FAR = 1;
  localparam int OVH_LINK_ID = 0;
  localparam logic [7:0] SA_FLAGS_MASK = 8'h3F;
  localparam logic [7:0] OVH_MASK = 8'h3F;
  localparam logic [7:0] STATUS_MASK = 8'h07;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ==========================================================
  // codeword patterns
  localparam logic [3:0] NT_CRC_CODE_A = 4'h2;
  localparam logic [3:0] NT_CRC_CODE_B = 4'h3;
  localparam logic [3:0] NT_FAR_CODE_A = 4'h1;
  localparam logic [3:0] NT_FAR_CODE_B = 4'h3;
  localparam logic [11:0] SPECIAL_888 = 12'h888;
  localparam logic [11:0] SPECIAL_AAA = 12'hAAA;
  localparam logic [11:0] SPECIAL_CCC = 12'hCCC;
  localparam logic [11:0] SPECIAL_EEE = 12'hEEE;
  localparam logic [11:0] SPECIAL_FFF = 12'hFFF;
  localparam logic [3:0] SA6_BITS_NEEDED = 4'hC;
  localparam logic [1:0] SA6_WORDS_NEEDED = 2'h3;
  localparam logic [1:0] SA7_WINDOW = 2'h3;
  localparam logic [1:0] SA7_ZEROS_NEEDED = 2'h2;

  // ==========================================================
  // timing
  localparam longint CLK_FREQ_HZ = 125_000_000;
  localparam longint RAI_TIME_MS = 10;
  localparam longint RAI_CYCLES = (CLK_FREQ_HZ * RAI_TIME_MS + 999) / 1000;
  localparam longint SECOND_S = 1;
  localparam longint SECOND_CYCLES = CLK_FREQ_HZ * SECOND_S;
  localparam logic [15:0] FEBE_MIN_PER_SEC = 16'h03DE;
  localparam int FEBE_SECONDS = 5;

  // ==========================================================
  // whole state of the block
  typedef struct packed {
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_idx;
    logic [31:0] hrdata;
    logic [7:0] sa_ctrl;
    logic [7:0] ovh_en;
    logic [7:0] sa_flags;
    logic [7:0] ovh_flags;
    logic [4:0][3:0] code_cur;
    logic [4:0][3:0] code_prev;
    logic [11:0] sa6_bits;
    logic [3:0] sa6_bcnt;
    logic [11:0] sa6_words;
    logic [1:0] sa6_wcnt;
    logic [2:0] sa7_hist;
    logic [1:0] sa7_cnt;
    logic e_zero_last;
    logic [31:0] rai_cnt;
    logic rai_stat;
    logic [31:0] sec_cnt;
    logic [15:0] zero_cnt;
    logic [FEBE_SECONDS-1:0] cf_hist;
    logic cf_stat;
    logic link_stat;
  } eof_state_type;

endpackage : eof_pkg
`default_nettype wire

// File: test/eof_event_flags_tb.sv
// self-checking bench for the overhead event flag block
`default_nettype none
module eof_event_flags_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // stimulus, design and reference model state
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, irq_n;
  logic crc_mf_sync = 1'b0;
  logic basic_frame_sync = 1'b0;
  logic smf_valid = 1'b0;
  logic sa6_bit_valid = 1'b0;
  logic sa6_bit = 1'b0;
  logic sa7_bit_valid = 1'b0;
  logic sa7_bit = 1'b0;
  logic e_bit_valid = 1'b0;
  logic e_bit = 1'b1;
  logic a_bit = 1'b0;
  logic [3:0] nat4_code = 4'h0;
  logic [3:0] nat5_code = 4'h0;
  logic [3:0] nat6_code = 4'h0;
  logic [3:0] nat7_code = 4'h0;
  logic [3:0] nat8_code = 4'h0;
  int errors = 0;
  int checked = 0;
  int seed = 24;
  int m_ctrl, m_en, m_sa, m_ovh, m_stat, m_w, m_wc, m_b, m_bc, m_s7, m_s7c;
  int m_cur[5];
  int m_prx[5];

  // long counts shortened so the whole run stays short
  eof_event_flags #(.RAI_HOLD_CYCLES(20), .SECOND_LEN_CYCLES(1000)) uut (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .crc_mf_sync(crc_mf_sync),
    .basic_frame_sync(basic_frame_sync), .smf_valid(smf_valid),
    .nat4_code(nat4_code), .nat5_code(nat5_code), .nat6_code(nat6_code),
    .nat7_code(nat7_code), .nat8_code(nat8_code),
    .sa6_bit_valid(sa6_bit_valid), .sa6_bit(sa6_bit),
    .sa7_bit_valid(sa7_bit_valid), .sa7_bit(sa7_bit),
    .e_bit_valid(e_bit_valid), .e_bit(e_bit), .a_bit(a_bit), .irq_n(irq_n));

  // 125 MHz clock
  always #4 clk = ~clk;

  // ==========================================================
  // helpers
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic bit special(input int x);
    return x inside {32'h888, 32'hAAA, 32'hCCC, 32'hEEE, 32'hFFF};
  endfunction : special

  task automatic final_report();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one single transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic rchk(input logic [31:0] a, input int e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask : rchk

  // write, mirrored into the model; flag registers clear on one
  task automatic wreg(input logic [31:0] a, input int d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    if (a == 32'h170) m_ctrl = d & 32'hFF;
    if (a == 32'h180) m_en = d & 32'h3F;
    if (a == 32'h174) m_sa &= ~d;
    if (a == 32'h184) m_ovh &= ~d;
  endtask : wreg

  task automatic check_all();
    rchk(32'h174, m_sa, "sa_flags");
    rchk(32'h184, m_ovh, "ovh_flags");
    rchk(32'h17C, m_stat, "status");
    for (int i = 0; i < 5; i++) begin
      rchk(32'h158 + 4 * i, m_cur[i], "code");
    end
    chk("irq_n", {31'h0, ((m_sa & m_ctrl & 32'h3F) | (m_ovh & m_en)) == 0},
        {31'h0, irq_n});
  endtask : check_all

  // one line-side pulse: 0 sub-multiframe, 1 Sa6, 2 Sa7, 3 E bit
  task automatic pulse(input int kind, input logic [19:0] c);
    logic [3:0] v;
    int z;
    @(posedge clk);
    case (kind)
      0: begin
        smf_valid <= 1'b1;
        {nat4_code, nat5_code, nat6_code, nat7_code, nat8_code} <= c;
      end
      1: begin
        sa6_bit_valid <= 1'b1;
        sa6_bit <= c[0];
      end
      2: begin
        sa7_bit_valid <= 1'b1;
        sa7_bit <= c[0];
      end
      default: begin
        e_bit_valid <= 1'b1;
        e_bit <= c[0];
      end
    endcase
    @(posedge clk);
    smf_valid <= 1'b0;
    sa6_bit_valid <= 1'b0;
    sa7_bit_valid <= 1'b0;
    e_bit_valid <= 1'b0;
    if (crc_mf_sync && kind == 0) begin
      for (int i = 0; i < 5; i++) begin
        v = c[19 - 4 * i -: 4];
        if (!m_ctrl[6] || v == m_prx[i]) begin
          if (v != m_cur[i]) m_sa |= 32'h10 >> i;
          m_cur[i] = v;
        end
        m_prx[i] = v;
      end
      v = c[11:8];
      if (v == 4'h2 || v == 4'h3) m_ovh |= 32'h20;
      if (v == 4'h1 || v == 4'h3) m_ovh |= 32'h10;
      // word compare only collects codewords while it is the chosen mode
      if (m_ctrl[7]) begin
        m_w = ((m_w << 4) | v) & 32'hFFF;
        if (m_wc < 3) m_wc++;
        if (m_wc == 3 && special(m_w)) m_sa |= 32'h20;
      end
    end
    if (crc_mf_sync && kind == 1 && !m_ctrl[7]) begin
      m_b = ((m_b << 1) | c[0]) & 32'hFFF;
      if (m_bc < 12) m_bc++;
      if (!m_ctrl[7] && m_bc == 12 && special(m_b)) m_sa |= 32'h20;
    end
    if (basic_frame_sync && kind == 2) begin
      m_s7 = ((m_s7 << 1) | c[0]) & 32'h7;
      if (m_s7c < 3) m_s7c++;
      z = (m_s7c == 3 && $countones(m_s7) <= 1);
      if (z != m_stat[0]) m_ovh |= 32'h1;
      m_stat[0] = z[0];
    end
    if (crc_mf_sync && kind == 3 && !c[0]) m_ovh |= 32'h8;
  endtask : pulse

  // ==========================================================
  // hang guard, well past the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    final_report();
  end

  // main sequence
  initial begin
    logic [19:0] c;
    logic [11:0] pat;
    pat = 12'hEEE;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    crc_mf_sync <= 1'b1;
    basic_frame_sync <= 1'b1;
    check_all();
    rchk(32'h170, 0, "ctrl");
    rchk(32'h178, 0, "unmapped");
    wreg(32'h180, 32'hFF);
    rchk(32'h180, 32'h3F, "enables");
    wreg(32'h17C, 32'hFF);
    wreg(32'h400, 32'hFF);
    rchk(32'h400, 0, "unmapped");
    wreg(32'h170, 32'h3F);
    rchk(32'h170, 32'h3F, "ctrl");
    // serial compare, first bit is the msb; 11 bits must not match
    for (int i = 11; i >= 0; i--) begin
      pulse(1, {19'h0, pat[i]});
      if (i < 2) check_all();
    end
    repeat (6) begin
      c = rnd();
      pulse(0, c);
      check_all();
    end
    wreg(32'h174, 0);
    check_all();
    wreg(32'h174, 32'h3F);
    wreg(32'h184, 32'h3F);
    check_all();
    // out of multiframe sync nothing may move
    @(posedge clk);
    crc_mf_sync <= 1'b0;
    m_wc = 0;
    m_bc = 0;
    pulse(0, 20'h33333);
    pulse(3, 20'h0);
    check_all();
    @(posedge clk);
    crc_mf_sync <= 1'b1;
    for (int k = 1; k < 4; k++) begin
      pulse(0, {5{k[3:0]}});
      check_all();
      wreg(32'h184, 32'h3F);
      wreg(32'h174, 32'h3F);
    end
    pulse(3, 20'h1);
    pulse(3, 20'h0);
    check_all();
    // debounce and word-mode special compare
    wreg(32'h170, 32'hFF);
    repeat (5) begin
      c = rnd();
      pulse(0, c);
      check_all();
      pulse(0, c);
      check_all();
    end
    wreg(32'h174, 32'h3F);
    repeat (3) begin
      pulse(0, 20'h88888);
      check_all();
    end
    // link id with its enable off, then on
    wreg(32'h184, 32'h3F);
    wreg(32'h174, 32'h3F);
    wreg(32'h180, 32'h3E);
    pulse(2, 20'h1);
    pulse(2, 20'h0);
    pulse(2, 20'h0);
    check_all();
    wreg(32'h180, 32'h3F);
    check_all();
    pulse(2, 20'h1);
    pulse(2, 20'h1);
    check_all();
    // two fresh zeros after a clear must raise the change flag again
    wreg(32'h184, 32'h1);
    pulse(2, 20'h0);
    pulse(2, 20'h0);
    check_all();
    // stream of E zeros with A one; kept running during the reads
    wreg(32'h184, 32'h3F);
    @(posedge clk);
    a_bit <= 1'b1;
    e_bit <= 1'b0;
    e_bit_valid <= 1'b1;
    repeat (6500) @(posedge clk);
    m_ovh |= 32'hE;
    m_stat |= 32'h6;
    check_all();
    wreg(32'h184, 32'h6);
    @(posedge clk);
    e_bit_valid <= 1'b0;
    a_bit <= 1'b0;
    repeat (2500) @(posedge clk);
    m_ovh |= 32'h6;
    m_stat &= ~32'h6;
    check_all();
    final_report();
  end
endmodule : eof_event_flags_tb
`default_nettype wire
